// file: core/acc_defines.svh
`ifndef ACC_DEFINES_SVH
`define ACC_DEFINES_SVH

// register byte addresses (word aligned)
`define ACC_OFS_MODE        5'h00
`define ACC_OFS_RES         5'h04
`define ACC_OFS_CHAN        5'h08
`define ACC_OFS_IRQF        5'h0c
`define ACC_OFS_IRQM        5'h10
`define ACC_OFS_GATE        5'h14
`define ACC_OFS_STAT        5'h18

// field positions
`define ACC_BIT_RUN         7
`define ACC_BIT_DIVHI       4
`define ACC_BIT_DIVLO       3
`define ACC_BIT_LV          1
`define ACC_BIT_CMP         0
`define ACC_BIT_RES         0
`define ACC_BIT_IRQ         1
`define ACC_BIT_GATE        5

// reset values
`define ACC_RST_MODE        8'h00
`define ACC_RST_RES         8'h00
`define ACC_RST_CHAN        8'h00
`define ACC_RST_IRQM_FIXED  8'hfe
`define ACC_MASK_FIXED      8'hf8

// conversion lengths in converter clocks
`define ACC_LEN_10_STD      5'd23
`define ACC_LEN_10_LV       5'd17
`define ACC_LEN_8_STD       5'd21
`define ACC_LEN_8_LV        5'd15
`define ACC_SMP_8_STD       5'd9
`define ACC_SMP_8_LV        5'd3
`define ACC_SMP_10_STD      5'd9
`define ACC_SMP_10_LV       5'd5

`endif

// file: core/acc_pkg.sv
package acc_pkg;
    typedef enum logic [1:0] {ACC_ST_IDLE, ACC_ST_SAMPLE, ACC_ST_CONVERT} acc_state_t;
endpackage

// file: core/acc_clk_if.sv
`timescale 1ns/100ps
interface acc_clk_if;
    logic       enable;
    logic [1:0] div_code;
    logic       tick;
    modport ctl (output enable, output div_code, input tick);
    modport div (input enable, input div_code, output tick);
endinterface

// file: core/acc_clkdiv.sv
`timescale 1ns/100ps
`include "acc_defines.svh"
module acc_clkdiv
(
    // clock and reset
    input  wire logic clk,
    input  wire logic rst_n,
    // control and tick
    acc_clk_if.div    cif
);
    logic [2:0] cnt_q;
    logic [2:0] cnt_d;
    logic [2:0] last;
    logic       wrap;
    logic       tick_q;

    // 00 -> /8, 01 -> /4, 10 -> /2, 11 -> undivided
    assign last  = (cif.div_code == 2'h0) ? 3'h7 :
                   (cif.div_code == 2'h1) ? 3'h3 :
                   (cif.div_code == 2'h2) ? 3'h1 : 3'h0;
    assign wrap  = (cnt_q >= last);
    assign cnt_d = !cif.enable ? 3'h0 : (wrap ? 3'h0 : cnt_q + 3'h1);
    assign cif.tick = tick_q;

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            cnt_q  <= 3'h0;
            tick_q <= 1'b0;
        end
        else
        begin
            cnt_q  <= cnt_d;
            tick_q <= cif.enable && wrap;
        end
    end
endmodule

// file: core/acc_top.sv
// Added by the designer: the Avalon-MM register port and the address map.
`timescale 1ns/100ps
`include "acc_defines.svh"

// Function
// - divider code picks clock /8 /4 /2 /1
// - 8-bit: 21 or 15 clocks
// - resolution bit 0; upper bits read zero
// - channel code selects inputs, upper zero
// - code 111 selects internal reference
// - irq flag bit 1, cleared by writing 0
// - mask bit 1 gates; bits 7-3 read one
// - run bit 7 enables conversion with bit 0 and gate bit set
// - comparator enable bit 0 runs comparator while gate bit set
// - clock gate bit supplies converter clock
// - 10-bit: 23 or 17 clocks
// - flag set at each conversion end
module acc_top
#(
    parameter int CHAN_BITS = 3
)
(
    // clock and reset
    input  wire logic        clk,
    input  wire logic        rst_n,
    // avalon-mm slave
    input  wire logic [4:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    input  wire logic [3:0]  avs_byteenable,
    output logic      [31:0] avs_readdata,
    output logic             avs_waitrequest,
    // analog front end control
    output logic             cmp_on,
    output logic             sample_on,
    output logic      [2:0]  chan_sel,
    output logic             ref_sel,
    output logic             eoc_pulse,
    output logic             irq_req
);

    // ************************************************************
    // registers
    // ************************************************************
    logic [7:0] mode_q;
    logic       res_q;
    logic [2:0] chan_q;
    logic       irqf_q;
    logic       irqm_q;
    logic       gate_q;
    logic       ack_q;
    logic       wait_q;
    logic [31:0] rdata_q;

    logic       req;
    logic       wr_en;
    logic       lane0;
    logic       hit_mode;
    logic       hit_res;
    logic       hit_chan;
    logic       hit_irqf;
    logic       hit_irqm;
    logic       hit_gate;
    logic       hit_stat;
    logic [7:0] wb;
    logic [7:0] rd_byte;
    logic [2:0] chan_mask;

    // one wait cycle: request answered on the second edge
    assign req      = (avs_read || avs_write) && !ack_q;
    // writes land only on the edge that completes the transfer
    assign wr_en    = avs_write && ack_q;
    assign lane0    = avs_byteenable[0];
    assign wb       = avs_writedata[7:0];
    assign hit_mode = ({avs_address[4:2], 2'b00} == `ACC_OFS_MODE);
    assign hit_res  = ({avs_address[4:2], 2'b00} == `ACC_OFS_RES);
    assign hit_chan = ({avs_address[4:2], 2'b00} == `ACC_OFS_CHAN);
    assign hit_irqf = ({avs_address[4:2], 2'b00} == `ACC_OFS_IRQF);
    assign hit_irqm = ({avs_address[4:2], 2'b00} == `ACC_OFS_IRQM);
    assign hit_gate = ({avs_address[4:2], 2'b00} == `ACC_OFS_GATE);
    assign hit_stat = ({avs_address[4:2], 2'b00} == `ACC_OFS_STAT);
    // code width limited by package size
    assign chan_mask = (CHAN_BITS >= 3) ? 3'h7 : 3'h3;

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            ack_q <= 1'b0;
        end
        else
        begin
            ack_q <= req;
        end
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            mode_q <= `ACC_RST_MODE;
            res_q  <= 1'b0;
            chan_q <= 3'h0;
            irqm_q <= 1'b1;
            gate_q <= 1'b0;
        end
        else if (wr_en && lane0)
        begin
            if (hit_mode)
                mode_q <= wb & 8'h9b;
            if (hit_res)
                res_q <= wb[`ACC_BIT_RES];
            if (hit_chan)
                chan_q <= wb[2:0] & chan_mask;
            if (hit_irqm)
                irqm_q <= wb[`ACC_BIT_IRQ];
            if (hit_gate)
                gate_q <= wb[`ACC_BIT_GATE];
        end
    end

    // ************************************************************
    // conversion sequencer
    // ************************************************************
    acc_clk_if cif ();
    acc_pkg::acc_state_t st_q;
    acc_pkg::acc_state_t st_d;
    logic [4:0] cnt_q;
    logic [4:0] cnt_d;
    logic [4:0] conv_len;
    logic [4:0] smp_len;
    logic       active;
    logic       done;
    logic       run;
    logic       lv;

    // clock only while gate bit set
    assign cif.enable   = gate_q;
    assign cif.div_code = {mode_q[`ACC_BIT_DIVHI], mode_q[`ACC_BIT_DIVLO]};
    assign lv  = mode_q[`ACC_BIT_LV];
    assign run = mode_q[`ACC_BIT_RUN] && mode_q[`ACC_BIT_CMP] && gate_q;

    // length by resolution and timing mode
    assign conv_len = res_q ? (lv ? `ACC_LEN_8_LV : `ACC_LEN_8_STD)
                            : (lv ? `ACC_LEN_10_LV : `ACC_LEN_10_STD);
    assign smp_len  = res_q ? (lv ? `ACC_SMP_8_LV : `ACC_SMP_8_STD)
                            : (lv ? `ACC_SMP_10_LV : `ACC_SMP_10_STD);

    acc_clkdiv u_div
    (
        .clk   (clk),
        .rst_n (rst_n),
        .cif   (cif)
    );

    assign active = (st_q != acc_pkg::ACC_ST_IDLE);
    assign done   = active && cif.tick && (cnt_q == conv_len - 5'd1);

    always_comb
    begin
        st_d  = st_q;
        cnt_d = cnt_q;
        if (!run)
        begin
            st_d  = acc_pkg::ACC_ST_IDLE;
            cnt_d = 5'h0;
        end
        else
        begin
            unique case (st_q)
                acc_pkg::ACC_ST_IDLE:
                begin
                    st_d  = acc_pkg::ACC_ST_SAMPLE;
                    cnt_d = 5'h0;
                end
                acc_pkg::ACC_ST_SAMPLE:
                begin
                    if (cif.tick)
                    begin
                        cnt_d = cnt_q + 5'd1;
                        if (cnt_q == smp_len - 5'd1)
                            st_d = acc_pkg::ACC_ST_CONVERT;
                    end
                end
                acc_pkg::ACC_ST_CONVERT:
                begin
                    if (done)
                    begin
                        st_d  = acc_pkg::ACC_ST_SAMPLE;
                        cnt_d = 5'h0;
                    end
                    else if (cif.tick)
                    begin
                        cnt_d = cnt_q + 5'd1;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            st_q  <= acc_pkg::ACC_ST_IDLE;
            cnt_q <= 5'h0;
        end
        else
        begin
            st_q  <= st_d;
            cnt_q <= cnt_d;
        end
    end

    // ************************************************************
    // interrupt flag
    // ************************************************************
    logic irqf_clr;

    assign irqf_clr = wr_en && lane0 && hit_irqf && !wb[`ACC_BIT_IRQ];

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            irqf_q <= 1'b0;
        end
        // set wins over a clear in the same cycle
        else if (done)
        begin
            irqf_q <= 1'b1;
        end
        else if (irqf_clr)
        begin
            irqf_q <= 1'b0;
        end
    end

    // ************************************************************
    // read mux and outputs
    // ************************************************************
    assign rd_byte =
        hit_mode ? mode_q :
        hit_res  ? {7'h00, res_q} :
        hit_chan ? {5'h00, chan_q} :
        hit_irqf ? {6'h00, irqf_q, 1'b0} :
        hit_irqm ? (`ACC_MASK_FIXED | {6'h00, irqm_q, 1'b0}) :
        hit_gate ? {2'h0, gate_q, 5'h00} :
        hit_stat ? {3'h0, cnt_q} : 8'h00;

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            rdata_q <= 32'h0;
        end
        else if (avs_read && !ack_q)
        begin
            rdata_q <= hit_stat ? {22'h0, active, st_q == acc_pkg::ACC_ST_SAMPLE, rd_byte} : {24'h0, rd_byte};
        end
    end

    assign avs_readdata    = rdata_q;
    assign avs_waitrequest = wait_q;

    // registered waitrequest: high while idle, low only in the answer cycle
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            wait_q <= 1'b1;
        end
        else
        begin
            wait_q <= !req;
        end
    end

    // ************************************************************
    // front end outputs
    // ************************************************************
    logic cmp_on_d;
    logic sample_on_d;
    logic ref_sel_d;
    logic irq_req_d;

    assign cmp_on_d    = mode_q[`ACC_BIT_CMP] && gate_q;
    assign sample_on_d = run && (st_d == acc_pkg::ACC_ST_SAMPLE);
    assign ref_sel_d   = (CHAN_BITS >= 3) && (chan_q == 3'h7);
    // mask 0 lets the request out
    // end event or-ed in so the request does not trail the pulse
    assign irq_req_d   = (irqf_q || done) && !irqm_q;

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            cmp_on    <= 1'b0;
            sample_on <= 1'b0;
        end
        else
        begin
            cmp_on    <= cmp_on_d;
            sample_on <= sample_on_d;
        end
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            chan_sel <= 3'h0;
            ref_sel  <= 1'b0;
        end
        else
        begin
            chan_sel <= chan_q;
            ref_sel  <= ref_sel_d;
        end
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            eoc_pulse <= 1'b0;
            irq_req   <= 1'b0;
        end
        else
        begin
            eoc_pulse <= done;
            irq_req   <= irq_req_d;
        end
    end
endmodule

// file: dv/acc_checker.sv
`timescale 1ns/100ps
module acc_checker
#(
    parameter int CHAN_BITS = 3
)
(
    // clock, reset and bus
    input wire logic        clk,
    input wire logic        rst_n,
    input wire logic [4:0]  avs_address,
    input wire logic        avs_read,
    input wire logic        avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0]  avs_byteenable,
    input wire logic [31:0] avs_readdata,
    input wire logic        avs_waitrequest,
    // front end
    input wire logic        cmp_on,
    input wire logic        sample_on,
    input wire logic [2:0]  chan_sel,
    input wire logic        ref_sel,
    input wire logic        eoc_pulse,
    input wire logic        irq_req
);
    // ******
    // shadow of written registers
    // ******
    wire        wr_ok = avs_write && !avs_waitrequest && avs_byteenable[0];
    wire [2:0]  wsel  = avs_address[4:2];
    logic [7:0] mode_q;
    logic       gate_q;
    logic       mask_q;
    wire        cmp_en  = mode_q[0] && gate_q;
    wire        conv_en = cmp_en && mode_q[7];
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            mode_q <= 8'h00;
            gate_q <= 1'b0;
            mask_q <= 1'b1;
        end
        else if (wr_ok)
        begin
            if (wsel == 3'h0) mode_q <= avs_writedata[7:0];
            if (wsel == 3'h5) gate_q <= avs_writedata[5];
            if (wsel == 3'h4) mask_q <= avs_writedata[1];
        end
    end
    // ******
    // assertions
    // ******
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    a_eoc_single: assert property (eoc_pulse |=> !eoc_pulse)
        else $error("end pulse longer than one cycle");
    a_eoc_needs_run: assert property (!conv_en [*3] |=> !eoc_pulse)
        else $error("conversion end while stopped");
    a_sample_stops: assert property (!conv_en [*3] |=> !sample_on)
        else $error("sampling while stopped");
    a_cmp_follows: assert property (cmp_en [*3] |=> cmp_on)
        else $error("comparator not running");
    a_mask_blocks: assert property (mask_q [*2] |=> !irq_req)
        else $error("request while masked");
    a_irq_on_eoc: assert property (eoc_pulse && !mask_q |-> ##[0:2] irq_req)
        else $error("no request after conversion end");
    a_ref_code: assert property (ref_sel == (CHAN_BITS == 3 && chan_sel == 3'h7))
        else $error("reference select wrong");
    a_res_bit0: assert property (avs_read && !avs_waitrequest && wsel == 3'h1 |-> avs_readdata[31:1] == 31'h0)
        else $error("resolution upper bits set");
endmodule

bind acc_top acc_checker #(.CHAN_BITS(CHAN_BITS)) acc_checker_inst (.clk, .rst_n, .avs_address, .avs_read,
    .avs_write, .avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest, .cmp_on, .sample_on,
    .chan_sel, .ref_sel, .eoc_pulse, .irq_req);

// file: dv/acc_front_model.sv
`timescale 1ns/100ps
module acc_front_model
(
    // block outputs
    input  wire logic clk,
    input  wire logic rst_n,
    input  wire logic sample_on,
    input  wire logic eoc_pulse,
    // measured figures in clk cycles
    output int        period,
    output int        smp,
    output int        eocs
);
    // ******
    // timing monitor; analog side sends nothing back
    // ******
    int cyc_q;
    int run_q;
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            cyc_q <= 0;
            run_q <= 0;
            period <= 0;
            smp <= 0;
            eocs <= 0;
        end
        else
        begin
            cyc_q <= eoc_pulse ? 1 : cyc_q + 1;
            period <= eoc_pulse ? cyc_q : period;
            eocs <= eocs + int'(eoc_pulse);
            run_q <= sample_on ? run_q + 1 : 0;
            smp <= (!sample_on && run_q != 0) ? run_q : smp;
        end
    end
endmodule

// file: dv/adc_mode_channel_control_bench.sv
`timescale 1ns/100ps
module adc_mode_channel_control_bench;
    logic        clk = 1'b0;
    logic        rst_n = 1'b0;
    logic [4:0]  avs_address = 5'h00;
    logic        avs_read = 1'b0;
    logic        avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0;
    logic [3:0]  avs_byteenable = 4'hf;
    logic [31:0] avs_readdata, rdat;
    logic        avs_waitrequest, cmp_on, sample_on, ref_sel, eoc_pulse, irq_req;
    logic [2:0]  chan_sel;
    int          period, smp, eocs, mismatches = 0, comparisons = 0;
    int          ln[4] = '{23, 17, 21, 15};
    int          sm[4] = '{9, 5, 9, 3};
    always #2.5 clk = ~clk;
    acc_top acc_top_inst (.clk, .rst_n, .avs_address, .avs_read, .avs_write, .avs_writedata, .avs_byteenable,
        .avs_readdata, .avs_waitrequest, .cmp_on, .sample_on, .chan_sel, .ref_sel, .eoc_pulse, .irq_req);
    acc_front_model acc_front_model_inst (.clk, .rst_n, .sample_on, .eoc_pulse, .period, .smp, .eocs);
    // ******
    // tasks
    // ******
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp)
        begin
            mismatches++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // request held until a rising edge samples waitrequest low; data taken there
    task automatic bus(input logic w, input logic [4:0] a, input logic [7:0] d);
        int n;
        n = 0;
        @(posedge clk);
        avs_address <= a;
        avs_writedata <= {24'h0, d};
        avs_write <= w;
        avs_read <= !w;
        do
        begin
            @(posedge clk);
            n++;
        end
        while (avs_waitrequest && n < 50);
        rdat = avs_readdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
        chk(32'(n < 50), 32'h1);
    endtask
    task automatic rd_chk(input logic [4:0] a, input logic [31:0] exp);
        bus(1'b0, a, 8'h00);
        chk(rdat, exp);
    endtask
    task automatic wait_eocs(input int k);
        int t;
        t = eocs + k;
        repeat (3000) if (eocs < t) @(posedge clk);
        chk(32'(eocs >= t), 32'h1);
    endtask
    task end_of_test;
        $display("comparisons %0d mismatches %0d", comparisons, mismatches);
        if (mismatches == 0 && comparisons > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    initial
    begin
        #300000;
        mismatches++;
        end_of_test();
    end
    // ******
    // tests
    // ******
    initial
    begin
        int k;
        repeat (6) @(posedge clk);
        rst_n <= 1'b1;
        rd_chk(5'h00, 32'h00);
        rd_chk(5'h04, 32'h00);
        rd_chk(5'h08, 32'h00);
        rd_chk(5'h0c, 32'h00);
        rd_chk(5'h10, 32'hfa);
        rd_chk(5'h1c, 32'h00);
        $display("test reset values done");
        bus(1'b1, 5'h04, 8'hff);
        rd_chk(5'h04, 32'h01);
        bus(1'b1, 5'h08, 8'hff);
        rd_chk(5'h08, 32'h07);
        chk({31'h0, ref_sel}, 32'h1);
        bus(1'b1, 5'h08, 8'h03);
        repeat (2) @(posedge clk);
        chk({28'h0, ref_sel, chan_sel}, 32'h3);
        bus(1'b1, 5'h00, 8'hff);
        rd_chk(5'h00, 32'h9b);
        $display("test register fields done");
        repeat (100) @(posedge clk);
        chk({31'h0, cmp_on}, 32'h0);
        chk(32'(eocs), 32'h0);
        bus(1'b1, 5'h14, 8'h20);
        rd_chk(5'h14, 32'h20);
        $display("test clock gate done");
        for (int i = 0; i < 4; i++)
        begin
            bus(1'b1, 5'h04, {7'h0, i[1]});
            bus(1'b1, 5'h00, {3'b100, i[1:0], 1'b0, i[0], 1'b1});
            wait_eocs(3);
            chk(32'(period), 32'(ln[i] << (3 - i)));
            chk(32'(smp), 32'(sm[i] << (3 - i)));
        end
        $display("test conversion timing done");
        chk({31'h0, irq_req}, 32'h0);
        rd_chk(5'h0c, 32'h02);
        bus(1'b1, 5'h10, 8'h00);
        rd_chk(5'h10, 32'hf8);
        chk({31'h0, irq_req}, 32'h1);
        bus(1'b1, 5'h00, 8'h19);
        repeat (2) @(posedge clk);
        k = eocs;
        repeat (200) @(posedge clk);
        chk(32'(eocs), 32'(k));
        bus(1'b1, 5'h0c, 8'h00);
        rd_chk(5'h0c, 32'h00);
        chk({31'h0, irq_req}, 32'h0);
        $display("test interrupt done");
        end_of_test();
    end
endmodule
